/* File: tb/csf_engine_model.sv */
// protocol engine and far bus model for the slot filter bench
// assumes csf_pkg and one clk_sys domain; frames are offered by tb tasks
`timescale 1ns/1ps
module csf_engine_model (
	// clock
	input wire logic clk_sys,
	// receive side
	output logic rxSof,
	output logic rxDone,
	output csf_pkg::csf_rx_frame_t rxFrame,
	output logic busIdle,
	output logic bitTick,
	// transmit side
	input wire logic txValid,
	input csf_pkg::csf_tx_frame_t txFrame,
	input wire logic busDriveEnable,
	output logic txLost,
	output logic txDone
);
	import csf_pkg::*;
	csf_tx_frame_t sentQ[$];
	int cnt = 0;
	bit loseNext = 0;
	initial begin
		{rxSof, rxDone, bitTick, txLost, txDone} = '0;
		busIdle = 1'b1;
		rxFrame = '0;
	end
	// ==========================================================
	// frame on the bus: sof, then done with contents, then released
	task automatic rx(input logic [28:0] id, input logic [63:0] d, input logic own);
		rxSof <= 1'b1;
		busIdle <= 1'b0;
		@(posedge clk_sys) rxSof <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rxFrame <= '{id, 1'b0, 1'b0, 4'h8, d, own};
		rxDone <= 1'b1;
		@(posedge clk_sys) rxDone <= 1'b0;
		rxFrame <= ~rxFrame; // released lines show no stale frame
		busIdle <= 1'b1;
		repeat (6) @(posedge clk_sys);
	endtask
	// n bit times, one tick each four cycles
	task automatic tick(input int n);
		repeat (n) begin
			bitTick <= 1'b1;
			@(posedge clk_sys) bitTick <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
	endtask
	// offered frame is sent after ten cycles, or lost after three when loseNext is set, unless the node may not drive
	always @(posedge clk_sys) begin
		txDone <= 1'b0;
		txLost <= 1'b0;
		if (txValid === 1'b1 && busDriveEnable === 1'b1 && txDone !== 1'b1 && txLost !== 1'b1) begin
			cnt++;
			if (cnt == 3 && loseNext) begin
				cnt = 0;
				loseNext = 0;
				txLost <= 1'b1;
			end else if (cnt == 10) begin
				cnt = 0;
				txDone <= 1'b1;
				sentQ.push_back(txFrame);
			end
		end
	end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench of csf_slot_filter with an engine model
// assumes csf_pkg; apb master tasks, filter model in integers
`timescale 1ns/1ps
module tb_top;
	import csf_pkg::*;
	logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [4:0] ev = '0;
	logic [7:0] recIn = '0, tecIn = '0;
	logic rxSof, rxDone, busIdle, bitTick, txValid, txLost, txDone, counterClear;
	logic busDriveEnable, ackEnable, rxIrq, txIrq, errIrq, wakeIrq;
	csf_rx_frame_t rxFrame;
	csf_tx_frame_t txFrame, f;
	int errors = 0, check_count = 0, nRx = 0, nTx = 0, nErr = 0, nWake = 0, nClr = 0, gm;
	int fid[16];
	bit isRx[16];
	csf_slot_filter u_csf_slot_filter (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxSof(rxSof), .rxDone(rxDone), .rxFrame(rxFrame), .busIdle(busIdle), .bitTick(bitTick),
		.txValid(txValid), .txFrame(txFrame), .txLost(txLost), .txDone(txDone), .errPassiveIn(ev[0]),
		.busOffIn(ev[1]), .busErrIn(ev[4]), .wakeIn(ev[2]), .cntLoad(ev[3]), .recIn(recIn), .tecIn(tecIn),
		.counterClear(counterClear), .busDriveEnable(busDriveEnable), .ackEnable(ackEnable),
		.rxIrq(rxIrq), .txIrq(txIrq), .errIrq(errIrq), .wakeIrq(wakeIrq));
	csf_engine_model u_csf_engine_model (.clk_sys(clk_sys), .rxSof(rxSof), .rxDone(rxDone),
		.rxFrame(rxFrame), .busIdle(busIdle), .bitTick(bitTick), .txValid(txValid), .txFrame(txFrame),
		.busDriveEnable(busDriveEnable), .txLost(txLost), .txDone(txDone));
	// ==========================================================
	// clock, pulse counters, watchdog
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		nRx += (rxIrq === 1'b1);
		nTx += (txIrq === 1'b1);
		nErr += (errIrq === 1'b1);
		nWake += (wakeIrq === 1'b1);
		nClr += (counterClear === 1'b1);
	end
	initial begin
		#400000;
		errors++;
		summarize();
	end
	// ==========================================================
	// compare, verdict, apb master
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys) penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) begin
			errors++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		chk(nm, rd, exp);
	endtask
	task pulse(input int b);
		ev[b] <= 1'b1;
		@(posedge clk_sys) ev <= '0;
		@(posedge clk_sys);
	endtask
	function logic [11:0] sc(input int j);
		return {A_SCTL_PAGE, 4'(j), 2'b00};
	endfunction
	function logic [11:0] ram(input int j, input int w);
		return {1'b0, A_MEM_PAGE, 4'(j), 2'(w), 2'b00};
	endfunction
	// lowest receiving slot whose masked standard id matches
	function int pick(input int id);
		for (int j = 0; j < 14; j++) if (isRx[j] && ((id ^ fid[j]) & gm & 'h7FF) == 0) return j;
		return -1;
	endfunction
	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] d0, d1;
		int id, s, k;
		void'($urandom(92732));
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rc("gmask", A_GMASK, 32'(RST_MASK));
		rc("ctl", A_CTL, 0);
		apb(1'b0, 12'h030, '0);
		chk("slverr", 32'(err), 1);
		$display("test reset done");
		gm = 'h7F0;
		wr(A_GMASK, gm);
		wr(A_IE, 32'h0000FFFF);
		for (k = 0; k < 2; k++) begin
			s = k ? 5 : 2;
			fid[s] = k ? 'h123 : 'h120;
			isRx[s] = 1;
			wr(sc(s), 0);
			wr({A_SID_PAGE, 4'(s), 2'b00}, fid[s]);
			wr(sc(s), 32'h80);
		end
		for (k = 0; k < 4; k++) begin
			id = (k == 2) ? 'h300 : 'h120 + ($urandom % 16);
			d0 = $urandom;
			d1 = $urandom;
			s = (k == 3) ? -1 : pick(id);
			u_csf_engine_model.rx(29'(id), {d1, d0}, k == 3);
			chk("rx irq", nRx, (k < 2) ? k + 1 : 2);
			if (s >= 0) begin
				rc("status", A_STAT, 32'h10 | s);
				rc("slot ctl", sc(s), (k == 1) ? 32'h89 : 32'h81);
				rc("data lo", ram(s, 0), d0);
				rc("data hi", ram(s, 1), d1);
				rc("id word", ram(s, 3), id);
			end
		end
		// dual-slot catch-all: masks open, stores alternate between 14 and 15
		wr(A_CTL, 1);
		wr(A_LMA, 0);
		wr(A_LMB, 0);
		wr(sc(14), 32'h80);
		wr(sc(15), 32'h80);
		u_csf_engine_model.tick(5);
		for (k = 0; k < 2; k++) begin
			u_csf_engine_model.rx(29'h300, 64'(k), 1'b0);
			rc("dual mailbox_number", A_STAT, 32'h1E | k);
			rc("dual stamp", ram(14 + k, 2), 32'h00050008);
		end
		$display("test receive done");
		wr(A_STAT, 32'h10);
		wr(sc(1), 0);
		d0 = $urandom;
		wr(ram(1, 0), d0);
		wr(ram(1, 2), 8);
		u_csf_engine_model.loseNext = 1'b1;
		wr(sc(1), 32'h100);
		k = 0;
		while (u_csf_engine_model.sentQ.size() == 0 && k < 300) begin
			@(posedge clk_sys);
			k++;
		end
		chk("tx sent", u_csf_engine_model.sentQ.size(), 1);
		if (u_csf_engine_model.sentQ.size() > 0) begin
			f = u_csf_engine_model.sentQ.pop_front();
			chk("tx data", f.data[31:0], d0);
			chk("tx dlc", 32'(f.dlc), 8);
		end
		repeat (4) @(posedge clk_sys);
		rc("tx ctl", sc(1), 32'h102);
		rc("tx status", A_STAT, 32'h21);
		chk("tx irq", nTx, 1);
		wr(sc(1), 0);
		rc("tx cleared", sc(1), 0);
		$display("test transmit done");
		for (k = 0; k < 4; k++) begin
			wr(A_CTL, (k << 3) | 4);
			rc("stamp zero", A_TSC, 0);
			u_csf_engine_model.tick(16);
			rc("stamp", A_TSC, 16 >> k);
		end
		rc("clear bit", A_CTL, 32'h18);
		$display("test stamp done");
		wr(A_CTL, 32'h20);
		repeat (2) @(posedge clk_sys);
		chk("drive", {busDriveEnable, ackEnable}, 0);
		wr(A_CTL, 0);
		repeat (2) @(posedge clk_sys);
		chk("drive on", {busDriveEnable, ackEnable}, 3);
		$display("test listen done");
		recIn <= 8'($urandom);
		tecIn <= 8'($urandom);
		pulse(3);
		rc("errc", A_ERRC, {tecIn, recIn});
		for (k = 0; k < 3; k++) pulse(k);
		@(posedge clk_sys);
		chk("err irq", nErr, 2);
		chk("wake irq", nWake, 1);
		pulse(4);
		wr(A_CTL, 32'h80);
		pulse(4);
		@(posedge clk_sys);
		chk("bus err irq", nErr, 3);
		apb(1'b0, A_STAT, '0);
		chk("busoff", 32'(rd[8]), 1);
		wr(A_CTL, 32'h2);
		repeat (3) @(posedge clk_sys);
		chk("counter clear", nClr, 1);
		rc("errc zero", A_ERRC, 0);
		apb(1'b0, A_STAT, '0);
		chk("busoff off", 32'(rd[8]), 0);
		rc("config kept", A_GMASK, gm);
		$display("test fault done");
		summarize();
	end
endmodule

/* File: verilog/csf_pkg.sv */
// shared constants and carrier types of the slot filter and messaging block
// assumes one clock domain and a protocol engine on the same clock
package csf_pkg;

	// ==========================================================
	// geometry
	localparam int NSLOT = 16;
	localparam logic [3:0] SLOT_LMA = 4'hE;
	localparam logic [3:0] SLOT_LMB = 4'hF;
	localparam logic [28:0] WIDTH_STD = 29'h000007FF;
	localparam logic [28:0] WIDTH_EXT = 29'h1FFFFFFF;

	// ==========================================================
	// register byte offsets
	localparam logic [11:0] A_CTL = 12'h000;
	localparam logic [11:0] A_STAT = 12'h004;
	localparam logic [11:0] A_IE = 12'h008;
	localparam logic [11:0] A_FMT = 12'h00C;
	localparam logic [11:0] A_GMASK = 12'h010;
	localparam logic [11:0] A_LMA = 12'h014;
	localparam logic [11:0] A_LMB = 12'h018;
	localparam logic [11:0] A_TSC = 12'h01C;
	localparam logic [11:0] A_ERRC = 12'h020;
	localparam logic [5:0] A_SCTL_PAGE = 6'h01;
	localparam logic [5:0] A_SID_PAGE = 6'h02;
	localparam logic [2:0] A_MEM_PAGE = 3'h1;

	// ==========================================================
	// module_control bit positions
	localparam int B_DUAL = 0;
	localparam int B_FRET = 1;
	localparam int B_TSCLR = 2;
	localparam int B_TSDIV = 3;
	localparam int B_LISTEN = 5;
	localparam int B_LOOP = 6;
	localparam int B_BEIE = 7;

	// slot_control bit positions
	localparam int S_NEW = 0;
	localparam int S_SENT = 1;
	localparam int S_LOST = 3;
	localparam int S_LOCK = 5;
	localparam int S_REM = 6;
	localparam int S_RXREQ = 7;
	localparam int S_TXREQ = 8;

	// module_status write-one-to-clear positions
	localparam int ST_RSUCC = 4;
	localparam int ST_TSUCC = 5;

	// ==========================================================
	// reset values and counts
	localparam logic [28:0] RST_MASK = 29'h1FFFFFFF;
	localparam logic [15:0] RST_STAMP = 16'h0000;
	localparam logic [2:0] STORE_LAST = 3'h4;
	localparam logic [1:0] FETCH_LAST = 2'h2;

	// ==========================================================
	// carrier types
	typedef struct packed {
		logic [28:0] id;
		logic ide;
		logic rtr;
		logic [3:0] dlc;
		logic [63:0] data;
		logic own;
	} csf_rx_frame_t;

	typedef struct packed {
		logic [28:0] id;
		logic ide;
		logic rtr;
		logic [3:0] dlc;
		logic [63:0] data;
	} csf_tx_frame_t;

	// field order matches the slot_control bit positions
	typedef struct packed {
		logic txReq;
		logic rxReq;
		logic remote;
		logic lock;
		logic txAct;
		logic lost;
		logic upd;
		logic sent;
		logic new_data_flag;
	} csf_slot_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_FETCH = 3'b010,
		TX_SEND = 3'b100
	} csf_tx_state_t;

endpackage

/* File: verilog/csf_slot_filter.sv */
// slot filter and messaging: acceptance, slot flags, stamp, apb registers
// assumes a protocol engine on clk_sys giving frame pulses and bit ticks
// Notes on behaviour
// - global mask slots 0-13, A 14, B 15
// - compare 11 or 29 bits per format
// - dual catch-all takes ids unstored below
// - dual slots take both types, alternating
// - remote flag shows received frame type, cleared when a remote receiver answers
// - dual slots may be overwritten unread
// - forced return clears counters and bus-off
// - stamp counts bit time divided 1/2/4/8
// - stamp clear bit zeroes counter, self-clears
// - listen-only drives nothing onto bus
// - request bits decode slot mode
// - remote sender then becomes data receiver
// - remote receiver answers unless lock set
// - lowest matching slot number wins, except dual A/B alternation
// - own frames stored only in self_receive_enable, unacked
// - start of frame sets receiver state when no transmit is active or pending
// - new data with updating, updating clears
// - enabled reception interrupts, mailbox, success
// - unread overwrite sets lost, repeats updates
// - idle request starts, lost arbitration clears
// - success sets sent, interrupts if enabled
// - error and wake-up interrupt sources
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module csf_slot_filter (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// protocol engine, receive side
	input wire logic rxSof,
	input wire logic rxDone,
	input csf_pkg::csf_rx_frame_t rxFrame,
	input wire logic busIdle,
	input wire logic bitTick,
	// protocol engine, transmit side
	output logic txValid,
	output csf_pkg::csf_tx_frame_t txFrame,
	input wire logic txLost,
	input wire logic txDone,
	// fault confinement
	input wire logic errPassiveIn,
	input wire logic busOffIn,
	input wire logic busErrIn,
	input wire logic wakeIn,
	input wire logic cntLoad,
	input wire logic [7:0] recIn,
	input wire logic [7:0] tecIn,
	output logic counterClear,
	// bus drive and interrupt pulses
	output logic busDriveEnable,
	output logic ackEnable,
	output logic rxIrq,
	output logic txIrq,
	output logic errIrq,
	output logic wakeIrq
);
	import csf_pkg::*;

	typedef struct packed {
		logic dual;
		logic listen;
		logic loopb;
		logic beie;
		logic [1:0] tsDiv;
		logic [15:0] ie;
		logic [15:0] fmt;
		logic [28:0] gmask;
		logic [28:0] lma;
		logic [28:0] lmb;
		logic [15:0][28:0] sid;
		csf_slot_t [15:0] sl;
		logic [3:0] mailbox_number;
		logic rSucc;
		logic tSucc;
		logic rState;
		logic tState;
		logic bOff;
		logic ePas;
		logic [7:0] rec;
		logic [7:0] tec;
		logic [15:0] tsc;
		logic [2:0] tsPre;
		logic altB;
		logic [2:0] storeCnt;
		logic [3:0] storeSlot;
		csf_rx_frame_t rxHold;
		logic [15:0] stampHold;
		csf_tx_state_t tx;
		logic [3:0] txSlot;
		logic [1:0] fetchCnt;
		logic fetchPend;
		logic apbCnt;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		csf_tx_frame_t txOut;
		logic txValid;
		logic busDrive;
		logic ackEn;
		logic cntClr;
		logic rxInt;
		logic txInt;
		logic errInt;
		logic wakeInt;
	} csf_state_t;

	csf_state_t s;
	csf_state_t next_s;
	logic [15:0] hit;
	logic anyHit;
	logic [3:0] pick;
	logic txCand;
	logic [3:0] txPick;
	logic apbOwn;
	logic commit;
	logic ramWe;
	logic [5:0] ramWa;
	logic [31:0] ramWd;
	logic [5:0] ramRa;
	logic [31:0] ramRd;
	logic [1:0] storeWord;

	// ==========================================================
	// bus handshake and ram ports
	assign apbOwn = psel && penable && !s.pready;
	assign commit = psel && penable && s.pready;
	assign storeWord = 2'(s.storeCnt - 3'h1);
	assign ramRa = apbOwn ? paddr[7:2] : {s.txSlot, s.fetchCnt};

	// store words win the write port; bus writes never coincide with a store
	always_comb begin
		ramWe = 1'b0;
		ramWa = {s.storeSlot, storeWord};
		ramWd = 32'h00000000;
		if (s.storeCnt != 3'h0) begin
			ramWe = 1'b1;
			case (storeWord)
				2'h0: ramWd = s.rxHold.data[31:0];
				2'h1: ramWd = s.rxHold.data[63:32];
				2'h2: ramWd = {s.stampHold, 12'h000, s.rxHold.dlc};
				default: ramWd = {3'h0, s.rxHold.id};
			endcase
		end else if (commit && pwrite && paddr[11:9] == 3'h0 && paddr[8:8] == A_MEM_PAGE[0]) begin
			ramWe = 1'b1;
			ramWa = paddr[7:2];
			ramWd = pwdata;
		end
	end

	csf_slot_ram u_ram (
		.clk_sys(clk_sys),
		.we(ramWe),
		.waddr(ramWa),
		.wdata(ramWd),
		.raddr(ramRa),
		.rdata(ramRd)
	);

	// ==========================================================
	// acceptance filter and slot choice
	always_comb begin
		logic [28:0] mask;
		logic [28:0] wmask;
		logic idOk;
		logic typeOk;
		mask = s.gmask;
		wmask = WIDTH_STD;
		idOk = 1'b0;
		typeOk = 1'b0;
		hit = 16'h0000;
		for (int j = 0; j < NSLOT; j++) begin
			mask = (4'(j) == SLOT_LMA) ? s.lma : (4'(j) == SLOT_LMB) ? s.lmb : s.gmask;
			wmask = s.fmt[j] ? WIDTH_EXT : WIDTH_STD;
			idOk = (((rxFrame.id ^ s.sid[j]) & mask & wmask) == 29'h0) && (rxFrame.ide == s.fmt[j]);
			if (s.dual && 4'(j) >= SLOT_LMA) begin
				typeOk = s.sl[j].rxReq && !s.sl[j].txReq;
			end else begin
				typeOk = (s.sl[j].rxReq && !s.sl[j].txReq && s.sl[j].remote == rxFrame.rtr)
					|| (s.sl[j].txReq && !s.sl[j].rxReq && s.sl[j].remote && !rxFrame.rtr
					&& !s.sl[j].txAct);
			end
			hit[j] = idOk && typeOk && (!rxFrame.own || s.loopb);
		end
		anyHit = hit != 16'h0000;
		pick = 4'h0;
		for (int j = NSLOT - 1; j >= 0; j--) begin
			if (hit[j]) begin
				pick = 4'(j);
			end
		end
		if (s.dual && pick == SLOT_LMA && hit[SLOT_LMB] && s.altB) begin
			pick = SLOT_LMB;
		end
	end

	// lowest slot ready to send
	always_comb begin
		txCand = 1'b0;
		txPick = 4'h0;
		for (int j = NSLOT - 1; j >= 0; j--) begin
			if (s.sl[j].txReq && !s.sl[j].rxReq && !s.sl[j].sent && !s.sl[j].lock && !s.sl[j].txAct) begin
				txCand = 1'b1;
				txPick = 4'(j);
			end
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		logic [2:0] dm;
		logic [3:0] k;
		logic hitAddr;
		logic [31:0] rd;
		next_s = s;
		k = paddr[5:2];
		hitAddr = 1'b0;
		rd = 32'h00000000;
		dm = 3'h0;
		next_s.rxInt = 1'b0;
		next_s.txInt = 1'b0;
		next_s.errInt = 1'b0;
		next_s.wakeInt = 1'b0;
		next_s.cntClr = 1'b0;
		next_s.pready = 1'b0;
		next_s.busDrive = !s.listen;
		next_s.ackEn = !s.listen && !(s.loopb && s.tx == TX_SEND);

		// bus read data and decode
		if (paddr[1:0] == 2'h0) begin
			hitAddr = 1'b1;
			if (paddr[11:6] == A_SCTL_PAGE) begin
				rd = 32'(s.sl[k]);
			end else if (paddr[11:6] == A_SID_PAGE) begin
				rd = {3'h0, s.sid[k]};
			end else if (paddr[11:9] == 3'h0 && paddr[8:8] == A_MEM_PAGE[0]) begin
				rd = ramRd;
			end else begin
				case (paddr)
					A_CTL: rd = {24'h0, s.beie, s.loopb, s.listen, s.tsDiv, 3'h0} | 32'(s.dual);
					A_STAT: rd = {22'h0, s.ePas, s.bOff, s.tState, s.rState, s.tSucc, s.rSucc, s.mailbox_number};
					A_IE: rd = {16'h0, s.ie};
					A_FMT: rd = {16'h0, s.fmt};
					A_GMASK: rd = {3'h0, s.gmask};
					A_LMA: rd = {3'h0, s.lma};
					A_LMB: rd = {3'h0, s.lmb};
					A_TSC: rd = {16'h0, s.tsc};
					A_ERRC: rd = {16'h0, s.tec, s.rec};
					default: hitAddr = 1'b0;
				endcase
			end
		end

		// access phase: one cycle to read the ram, then answer
		if (apbOwn) begin
			if (!s.apbCnt) begin
				next_s.apbCnt = 1'b1;
			end else if (s.storeCnt == 3'h0 && !rxDone) begin
				next_s.apbCnt = 1'b0;
				next_s.pready = 1'b1;
				next_s.pslverr = !hitAddr;
				next_s.prdata = hitAddr ? rd : 32'h00000000;
			end
		end

		// register writes take effect at the edge that sees pready
		if (commit && pwrite && hitAddr) begin
			if (paddr[11:6] == A_SCTL_PAGE) begin
				next_s.sl[k].new_data_flag = s.sl[k].new_data_flag & pwdata[S_NEW];
				next_s.sl[k].sent = s.sl[k].sent & pwdata[S_SENT];
				next_s.sl[k].lost = s.sl[k].lost & pwdata[S_LOST];
				next_s.sl[k].lock = pwdata[S_LOCK];
				next_s.sl[k].remote = pwdata[S_REM];
				next_s.sl[k].rxReq = pwdata[S_RXREQ];
				next_s.sl[k].txReq = pwdata[S_TXREQ];
			end else if (paddr[11:6] == A_SID_PAGE) begin
				next_s.sid[k] = pwdata[28:0];
			end
			case (paddr)
				A_CTL: begin
					next_s.dual = pwdata[B_DUAL];
					next_s.tsDiv = pwdata[B_TSDIV +: 2];
					next_s.listen = pwdata[B_LISTEN];
					next_s.loopb = pwdata[B_LOOP];
					next_s.beie = pwdata[B_BEIE];
					if (pwdata[B_FRET] && s.bOff) begin
						next_s.bOff = 1'b0;
						next_s.ePas = 1'b0;
						next_s.rec = 8'h00;
						next_s.tec = 8'h00;
						next_s.cntClr = 1'b1;
					end
				end
				A_STAT: begin
					next_s.rSucc = s.rSucc & !pwdata[ST_RSUCC];
					next_s.tSucc = s.tSucc & !pwdata[ST_TSUCC];
				end
				A_IE: next_s.ie = pwdata[15:0];
				A_FMT: next_s.fmt = pwdata[15:0];
				A_GMASK: next_s.gmask = pwdata[28:0];
				A_LMA: next_s.lma = pwdata[28:0];
				A_LMB: next_s.lmb = pwdata[28:0];
				default: ;
			endcase
		end

		// time stamp prescaler and counter
		dm = (s.tsDiv == 2'h0) ? 3'h0 : (s.tsDiv == 2'h1) ? 3'h1 : (s.tsDiv == 2'h2) ? 3'h3 : 3'h7;
		if (bitTick) begin
			next_s.tsPre = s.tsPre + 3'h1;
			if ((s.tsPre & dm) == dm) begin
				next_s.tsc = s.tsc + 16'h0001;
			end
		end
		if (commit && pwrite && paddr == A_CTL && pwdata[B_TSCLR]) begin
			next_s.tsc = RST_STAMP;
			next_s.tsPre = 3'h0;
		end

		// fault confinement events; hardware sets after the clear
		if (cntLoad) begin
			next_s.rec = recIn;
			next_s.tec = tecIn;
		end
		if (errPassiveIn) begin
			next_s.ePas = 1'b1;
		end
		if (busOffIn) begin
			next_s.bOff = 1'b1;
		end
		next_s.errInt = errPassiveIn || busOffIn || (busErrIn && s.beie);
		next_s.wakeInt = wakeIn;

		// message store, one word per cycle
		if (s.storeCnt != 3'h0) begin
			if (s.storeCnt == STORE_LAST) begin
				next_s.storeCnt = 3'h0;
				next_s.sl[s.storeSlot].upd = 1'b0;
			end else begin
				next_s.storeCnt = s.storeCnt + 3'h1;
			end
		end

		// start of frame and completed reception
		if (rxSof && s.tx == TX_IDLE && !txCand) begin
			next_s.rState = 1'b1;
		end
		if (rxDone) begin
			next_s.rState = 1'b0;
			if (anyHit) begin
				next_s.storeCnt = 3'h1;
				next_s.storeSlot = pick;
				next_s.rxHold = rxFrame;
				next_s.stampHold = s.tsc;
				next_s.sl[pick].lost = next_s.sl[pick].lost || s.sl[pick].new_data_flag;
				next_s.sl[pick].new_data_flag = 1'b1;
				next_s.sl[pick].upd = 1'b1;
				next_s.sl[pick].remote = rxFrame.rtr;
				if (s.dual && pick >= SLOT_LMA) begin
					next_s.altB = (pick == SLOT_LMA);
				end else if (s.sl[pick].txReq) begin
					next_s.sl[pick].txReq = 1'b0;
					next_s.sl[pick].rxReq = 1'b1;
				end else if (s.sl[pick].remote) begin
					next_s.sl[pick].remote = 1'b0;
					next_s.sl[pick].rxReq = 1'b0;
					next_s.sl[pick].txReq = 1'b1;
				end
				if (s.ie[pick]) begin
					next_s.rxInt = 1'b1;
					next_s.mailbox_number = pick;
					next_s.rSucc = 1'b1;
				end
			end
		end

		// transmit sequencing
		case (s.tx)
			TX_IDLE: begin
				if (txCand && busIdle && !s.listen) begin
					next_s.tx = TX_FETCH;
					next_s.txSlot = txPick;
					next_s.sl[txPick].txAct = 1'b1;
					next_s.tState = 1'b1;
					next_s.fetchCnt = 2'h0;
					next_s.fetchPend = 1'b0;
					next_s.txOut.id = s.sid[txPick];
					next_s.txOut.ide = s.fmt[txPick];
					next_s.txOut.rtr = s.sl[txPick].remote;
				end
			end
			TX_FETCH: begin
				if (s.fetchPend) begin
					next_s.fetchPend = 1'b0;
					next_s.fetchCnt = s.fetchCnt + 2'h1;
					case (s.fetchCnt)
						2'h0: next_s.txOut.data[31:0] = ramRd;
						2'h1: next_s.txOut.data[63:32] = ramRd;
						default: next_s.txOut.dlc = ramRd[3:0];
					endcase
					if (s.fetchCnt == FETCH_LAST) begin
						next_s.tx = TX_SEND;
						next_s.txValid = 1'b1;
					end
				end else if (!apbOwn) begin
					next_s.fetchPend = 1'b1;
				end
			end
			TX_SEND: begin
				if (txLost || s.listen) begin
					next_s.tx = TX_IDLE;
					next_s.txValid = 1'b0;
					next_s.sl[s.txSlot].txAct = 1'b0;
					next_s.tState = 1'b0;
				end else if (txDone) begin
					next_s.tx = TX_IDLE;
					next_s.txValid = 1'b0;
					next_s.tState = 1'b0;
					next_s.sl[s.txSlot].txAct = 1'b0;
					next_s.sl[s.txSlot].sent = 1'b1;
					if (s.sl[s.txSlot].remote) begin
						next_s.sl[s.txSlot].remote = 1'b0;
						next_s.sl[s.txSlot].txReq = 1'b0;
						next_s.sl[s.txSlot].rxReq = 1'b1;
					end
					if (s.ie[s.txSlot]) begin
						next_s.txInt = 1'b1;
						next_s.mailbox_number = s.txSlot;
						next_s.tSucc = 1'b1;
					end
				end
			end
			default: next_s.tx = TX_IDLE;
		endcase
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.gmask <= RST_MASK;
			s.lma <= RST_MASK;
			s.lmb <= RST_MASK;
			s.tx <= TX_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state register
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign txValid = s.txValid;
	assign txFrame = s.txOut;
	assign counterClear = s.cntClr;
	assign busDriveEnable = s.busDrive;
	assign ackEnable = s.ackEn;
	assign rxIrq = s.rxInt;
	assign txIrq = s.txInt;
	assign errIrq = s.errInt;
	assign wakeIrq = s.wakeInt;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_stamp_clear;
		commit && pwrite && paddr == A_CTL && pwdata[B_TSCLR] |=> s.tsc == 16'h0000;
	endproperty
	a_stamp_clear: assert property (p_stamp_clear) else $error("stamp not cleared");

	property p_busoff_return;
		commit && pwrite && paddr == A_CTL && pwdata[B_FRET] && s.bOff && !busOffIn
			|=> !s.bOff && s.rec == 8'h00 && s.tec == 8'h00 && counterClear;
	endproperty
	a_busoff_return: assert property (p_busoff_return) else $error("forced return failed");

	property p_listen;
		s.listen |=> !busDriveEnable && !ackEnable ##1 !txValid;
	endproperty
	a_listen: assert property (p_listen) else $error("bus driven in listen-only");

	property p_update_ends;
		rxDone && anyHit && s.storeCnt == 3'h0 |=> s.sl[s.storeSlot].upd && s.sl[s.storeSlot].new_data_flag
			##4 !s.sl[s.storeSlot].upd;
	endproperty
	a_update_ends: assert property (p_update_ends) else $error("updating flag timing");

	property p_sof;
		rxSof && !rxDone && s.tx == TX_IDLE && !txCand |=> s.rState;
	endproperty
	a_sof: assert property (p_sof) else $error("receiver state not set");

	property p_arb_lost;
		s.tx == TX_SEND && txLost |=> !s.tState && !s.sl[s.txSlot].txAct && !txValid;
	endproperty
	a_arb_lost: assert property (p_arb_lost) else $error("lost arbitration flags");

	property p_tx_done;
		s.tx == TX_SEND && txDone && !txLost && !s.listen && s.ie[s.txSlot]
			|=> s.sl[$past(s.txSlot)].sent && txIrq && s.tSucc && s.mailbox_number == $past(s.txSlot);
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("transmit success handling");

	property p_rx_irq;
		rxDone && anyHit && s.ie[pick] && !(s.tx == TX_SEND && txDone)
			|=> rxIrq && s.rSucc && s.mailbox_number == $past(pick);
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("reception interrupt missing");

	property p_own_frame;
		rxDone && rxFrame.own && !s.loopb |=> s.storeCnt == 3'h0;
	endproperty
	a_own_frame: assert property (p_own_frame) else $error("own frame stored");

	property p_answer;
		psel && penable && !pready |-> ##[1:12] pready;
	endproperty
	a_answer: assert property (p_answer) else $error("apb answer late");
endmodule

/* File: verilog/csf_slot_ram.sv */
// message contents of the sixteen slots, four words each
// assumes one write and one read per cycle; read data one cycle late
`timescale 1ns/1ps
module csf_slot_ram (
	// clock
	input wire logic clk_sys,
	// write port
	input wire logic we,
	input wire logic [5:0] waddr,
	input wire logic [31:0] wdata,
	// read port
	input wire logic [5:0] raddr,
	output logic [31:0] rdata
);
	logic [31:0] mem [0:63];

	// ==========================================================
	// storage with registered read
	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
